// >>> include/cpu_bus_cycle_monitor_regs.svh
`ifndef CPU_BUS_CYCLE_MONITOR_REGS_SVH
`define CPU_BUS_CYCLE_MONITOR_REGS_SVH

// Register byte offsets.
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_ADDR          8'h08
`define REG_DATA          8'h0c
`define REG_CYCLES        8'h10

// Control fields and reset values.
`define CTRL_WIDE_BIT     0
`define CTRL_IO_POL_BIT   1
`define CTRL_WIDE_RST     1'h1
`define CTRL_IO_POL_RST   1'h0

// Status register fields.
`define STAT_STATE_LO     0
`define STAT_QLEVEL_LO    4
`define STAT_LAST_BIT     8
`define STAT_SECOND_BIT   9
`define STAT_MIN_BIT      10
`define STAT_HOLD_BIT     11

// Positions inside the raw pin vector.
`define PIN_WIDTH         32
`define PIN_STATUS_HI     2
`define PIN_STATUS_LO     0
`define PIN_QS_HI         4
`define PIN_QS_LO         3
`define PIN_LOCK          5
`define PIN_RQGT0         6
`define PIN_RQGT1         7
`define PIN_AD_HI         23
`define PIN_AD_LO         8
`define PIN_A_HI          27
`define PIN_A_LO          24
`define PIN_BHE           28
`define PIN_READY         29
`define PIN_MIN_MODE      30
`define PIN_HOLD          31
// Idle pin levels: passive status, no queue op, ready high, high byte disabled.
`define PIN_RST           32'h300000e7

// Status line codes, active low lines read as a number.
`define STATUS_INTA       3'h0
`define STATUS_HALT       3'h3
`define STATUS_CODE       3'h4
`define STATUS_PASSIVE    3'h7

// Queue status codes.
`define QS_FIRST          2'h1
`define QS_FLUSH          2'h2
`define QS_NEXT           2'h3
`define QUEUE_MAX_WIDE    4'h6
`define QUEUE_MAX_NARROW  4'h4

`endif

// >>> include/cpu_bus_cycle_monitor_pkg.sv
package cpu_bus_cycle_monitor_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_WAIT,
        ST_T4
    } machine_state_e;

    typedef struct packed {
        logic [31:0]    pin_meta;
        logic [31:0]    pin_sync;
        logic [2:0]     status_prev;
        machine_state_e state;
        logic [2:0]     cycle_status;
        logic [19:0]    addr;
        logic           bhe_n;
        logic [15:0]    data;
        logic           ale;
        logic [3:0]     queue_level;
        logic           last_first;
        logic           second_last_first;
        logic           hold_ack;
        logic           wide;
        logic           io_pol;
        logic [31:0]    cycles;
        logic           ack;
        logic [31:0]    rdata;
        logic [7:0]     tgt_out;
        logic [7:0]     tgt_oe;
    } monitor_state_s;

endpackage : cpu_bus_cycle_monitor_pkg

// >>> hw/cpu_bus_cycle_monitor.sv
`timescale 1ns/1ps
`include "cpu_bus_cycle_monitor_regs.svh"

module cpu_bus_cycle_monitor (
    // Clock and reset.
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Processor and target pins, asynchronous to clock_i.
    input  wire logic [31:0] proc_pins_i,
    // Target control lines, two signals per pin: value and output enable.
    output logic      [7:0]  target_system_ctl_o,
    output logic      [7:0]  target_system_ctl_oe_o,
    // Logic analyzer side.
    output logic      [19:0] analyzer_addr_o,
    output logic      [15:0] analyzer_data_o,
    output logic             high_byte_enable_n_o,
    output logic             analyzer_read_write_o,
    output logic             analyzer_mem_io_o,
    output logic             analyzer_code_fetch_o,
    output logic             analyzer_t1_o,
    output logic             analyzer_wait_o,
    output logic             analyzer_idle_o,
    output logic             analyzer_ale_o,
    output logic             analyzer_min_mode_o,
    output logic             analyzer_hold_ack_o,
    output logic      [2:0]  analyzer_state_o,
    output logic      [3:0]  queue_level_o,
    output logic             last_byte_was_first_o,
    output logic             second_last_byte_was_first_o
);

    cpu_bus_cycle_monitor_pkg::monitor_state_s r_reg;
    cpu_bus_cycle_monitor_pkg::monitor_state_s r_next;

    // A read cycle is any active code other than a write, halt or acknowledge.
    function automatic logic is_read(input logic [2:0] code);
        is_read = (code == 3'h1) || (code == 3'h5) || (code == `STATUS_CODE);
    endfunction : is_read

    function automatic logic is_write(input logic [2:0] code);
        is_write = (code == 3'h2) || (code == 3'h6);
    endfunction : is_write

    // Bytes moved by one code fetch; both banks only on a wide, even, enabled access.
    function automatic logic [3:0] fetch_bytes(input logic wide,
                                               input logic a0,
                                               input logic bhe_n);
        fetch_bytes = (wide && !a0 && !bhe_n) ? 4'h2 : 4'h1;
    endfunction : fetch_bytes

    function automatic logic data_phase(input cpu_bus_cycle_monitor_pkg::machine_state_e s);
        data_phase = (s == cpu_bus_cycle_monitor_pkg::ST_T2) ||
                     (s == cpu_bus_cycle_monitor_pkg::ST_T3) ||
                     (s == cpu_bus_cycle_monitor_pkg::ST_WAIT) ||
                     (s == cpu_bus_cycle_monitor_pkg::ST_T4);
    endfunction : data_phase

    logic [2:0]  status_now;
    logic [1:0]  queue_code;
    logic        ready_now;
    logic        min_mode;
    logic        ale_now;
    logic        take_byte;
    logic [4:0]  level_sum;
    logic [3:0]  queue_max;
    logic [3:0]  fill;
    logic        bhe_eff_n;
    logic [2:0]  code_now;
    logic        in_data;
    logic [7:0]  emu_out;
    logic [7:0]  emu_oe;
    logic        bus_write;

    always_comb begin
        r_next = r_reg;
        // Only the second synchroniser stage is ever read.
        r_next.pin_meta = proc_pins_i;
        r_next.pin_sync = r_reg.pin_meta;

        status_now = r_reg.pin_sync[`PIN_STATUS_HI:`PIN_STATUS_LO];
        queue_code = r_reg.pin_sync[`PIN_QS_HI:`PIN_QS_LO];
        ready_now  = r_reg.pin_sync[`PIN_READY];
        min_mode   = r_reg.pin_sync[`PIN_MIN_MODE];
        r_next.status_prev = status_now;

        // A change away from passive announces a cycle; it is accepted only where a
        // new cycle may legally begin, so glitches mid-cycle cannot restart the tracker.
        ale_now = (r_reg.status_prev == `STATUS_PASSIVE) &&
                  (status_now != `STATUS_PASSIVE) &&
                  ((r_reg.state == cpu_bus_cycle_monitor_pkg::ST_IDLE) ||
                   (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_T4));
        r_next.ale = ale_now;

        case (r_reg.state)
            cpu_bus_cycle_monitor_pkg::ST_IDLE: begin
                if (ale_now) begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_T1;
                end else begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_IDLE;
                end
            end
            cpu_bus_cycle_monitor_pkg::ST_T1: begin
                r_next.state = cpu_bus_cycle_monitor_pkg::ST_T2;
            end
            cpu_bus_cycle_monitor_pkg::ST_T2: begin
                r_next.state = cpu_bus_cycle_monitor_pkg::ST_T3;
            end
            cpu_bus_cycle_monitor_pkg::ST_T3: begin
                if (ready_now) begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_T4;
                end else begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_WAIT;
                end
            end
            cpu_bus_cycle_monitor_pkg::ST_WAIT: begin
                if (ready_now) begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_T4;
                end else begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_WAIT;
                end
            end
            cpu_bus_cycle_monitor_pkg::ST_T4: begin
                if (ale_now) begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_T1;
                end else begin
                    r_next.state = cpu_bus_cycle_monitor_pkg::ST_IDLE;
                end
            end
            default: begin
                r_next.state = cpu_bus_cycle_monitor_pkg::ST_IDLE;
            end
        endcase

        // The narrow variant never uses the high byte enable.
        bhe_eff_n = r_reg.wide ? r_reg.pin_sync[`PIN_BHE] : 1'h1;

        if (ale_now) begin
            r_next.cycle_status = status_now;
            r_next.addr  = {r_reg.pin_sync[`PIN_A_HI:`PIN_A_LO],
                            r_reg.pin_sync[`PIN_AD_HI:`PIN_AD_LO]};
            r_next.bhe_n = bhe_eff_n;
            r_next.cycles = r_reg.cycles + 32'h1;
        end

        // Data is sampled in the fourth state; wide takes both lanes whatever the address, narrow the low lane only.
        if (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_T4) begin
            if (r_reg.wide) begin
                r_next.data[7:0]  = r_reg.pin_sync[`PIN_AD_LO +: 8];
                r_next.data[15:8] = r_reg.pin_sync[`PIN_AD_HI -: 8];
            end else begin
                r_next.data = {8'h00, r_reg.pin_sync[`PIN_AD_LO +: 8]};
            end
        end

        // Queue follower. Fill counts only bus code fetches, so a discarded prefetch
        // still appears here until the flush code arrives.
        queue_max = r_reg.wide ? `QUEUE_MAX_WIDE : `QUEUE_MAX_NARROW;
        take_byte = (queue_code == `QS_FIRST) || (queue_code == `QS_NEXT);
        fill = 4'h0;
        if ((r_reg.state == cpu_bus_cycle_monitor_pkg::ST_T4) &&
            (r_reg.cycle_status == `STATUS_CODE)) begin
            fill = fetch_bytes(r_reg.wide, r_reg.addr[0], r_reg.bhe_n);
        end
        level_sum = {1'h0, r_reg.queue_level} + {1'h0, fill};
        if (take_byte && (level_sum != 5'h00)) begin
            level_sum = level_sum - 5'h01;
        end
        if (queue_code == `QS_FLUSH) begin
            r_next.queue_level = 4'h0;
        end else if (level_sum > {1'h0, queue_max}) begin
            r_next.queue_level = queue_max;
        end else begin
            r_next.queue_level = level_sum[3:0];
        end
        if (take_byte) begin
            r_next.second_last_first = r_reg.last_first;
            r_next.last_first = (queue_code == `QS_FIRST);
        end

        // Hold is granted only between cycles and released as soon as the target drops it.
        r_next.hold_ack = min_mode && r_reg.pin_sync[`PIN_HOLD] &&
                          (r_reg.hold_ack ||
                           (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_IDLE));

        // Minimum mode emulation from the maximum mode status.
        code_now  = r_reg.cycle_status;
        in_data   = data_phase(r_next.state);
        bus_write = is_write(code_now);
        emu_out[0] = !(in_data && (code_now != `STATUS_HALT));
        emu_out[1] = code_now[1];
        emu_out[2] = code_now[2] ^ r_reg.io_pol;
        emu_out[3] = !(in_data && bus_write);
        emu_out[4] = ale_now;
        emu_out[5] = !(in_data && (code_now == `STATUS_INTA) &&
                       (r_next.state != cpu_bus_cycle_monitor_pkg::ST_T4));
        emu_out[6] = 1'h0;
        emu_out[7] = r_next.hold_ack;
        emu_oe = 8'hff;
        emu_oe[6] = 1'h0;

        for (int i = 0; i < 8; i++) begin
            if (min_mode) begin
                r_next.tgt_out[i] = emu_out[i];
                r_next.tgt_oe[i]  = emu_oe[i];
            end else begin
                r_next.tgt_out[i] = r_reg.pin_sync[i];
                r_next.tgt_oe[i]  = 1'h1;
            end
        end
        // Lines 0 to 2, 4 and 5 float during hold; line 3 stays driven.
        if (min_mode && r_next.hold_ack) begin
            r_next.tgt_oe[0] = 1'h0;
            r_next.tgt_oe[1] = 1'h0;
            r_next.tgt_oe[2] = 1'h0;
            r_next.tgt_oe[4] = 1'h0;
            r_next.tgt_oe[5] = 1'h0;
        end

        // Wishbone slave: one wait cycle, ack for every address, unmapped reads zero.
        r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
        r_next.rdata = 32'h0;
        if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
            if (wb_we_i && wb_sel_i[0] && (wb_adr_i == `REG_CTRL)) begin
                r_next.wide   = wb_dat_i[`CTRL_WIDE_BIT];
                r_next.io_pol = wb_dat_i[`CTRL_IO_POL_BIT];
            end
            case (wb_adr_i)
                `REG_CTRL: begin
                    r_next.rdata[`CTRL_WIDE_BIT]   = r_reg.wide;
                    r_next.rdata[`CTRL_IO_POL_BIT] = r_reg.io_pol;
                end
                `REG_STATUS: begin
                    r_next.rdata[`STAT_STATE_LO +: 3]  = r_reg.state;
                    r_next.rdata[`STAT_QLEVEL_LO +: 4] = r_reg.queue_level;
                    r_next.rdata[`STAT_LAST_BIT]       = r_reg.last_first;
                    r_next.rdata[`STAT_SECOND_BIT]     = r_reg.second_last_first;
                    r_next.rdata[`STAT_MIN_BIT]        = min_mode;
                    r_next.rdata[`STAT_HOLD_BIT]       = r_reg.hold_ack;
                end
                `REG_ADDR: begin
                    r_next.rdata = {12'h000, r_reg.addr};
                end
                `REG_DATA: begin
                    r_next.rdata = {16'h0000, r_reg.data};
                end
                `REG_CYCLES: begin
                    r_next.rdata = r_reg.cycles;
                end
                default: begin
                    r_next.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Synchroniser stages reset to idle pin levels, so that releasing reset
            // does not look like a status change and start a false cycle.
            r_reg.pin_meta          <= `PIN_RST;
            r_reg.pin_sync          <= `PIN_RST;
            r_reg.status_prev       <= `STATUS_PASSIVE;
            r_reg.state             <= cpu_bus_cycle_monitor_pkg::ST_IDLE;
            r_reg.cycle_status      <= `STATUS_PASSIVE;
            r_reg.addr              <= 20'h00000;
            r_reg.bhe_n             <= 1'h1;
            r_reg.data              <= 16'h0000;
            r_reg.ale               <= 1'h0;
            r_reg.queue_level       <= 4'h0;
            r_reg.last_first        <= 1'h0;
            r_reg.second_last_first <= 1'h0;
            r_reg.hold_ack          <= 1'h0;
            r_reg.wide              <= `CTRL_WIDE_RST;
            r_reg.io_pol            <= `CTRL_IO_POL_RST;
            r_reg.cycles            <= 32'h0;
            r_reg.ack               <= 1'h0;
            r_reg.rdata             <= 32'h0;
            r_reg.tgt_out           <= 8'hff;
            r_reg.tgt_oe            <= 8'h00;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_ack_o              = r_reg.ack;
    assign wb_dat_o              = r_reg.rdata;
    assign target_system_ctl_o   = r_reg.tgt_out;
    assign target_system_ctl_oe_o = r_reg.tgt_oe;

    // Analyzer outputs are bus conditions only; they do not prove execution.
    assign analyzer_addr_o       = r_reg.addr;
    assign analyzer_data_o       = r_reg.data;
    assign high_byte_enable_n_o  = r_reg.bhe_n;
    assign analyzer_read_write_o = is_read(r_reg.cycle_status);
    assign analyzer_mem_io_o     = r_reg.cycle_status[2] ^ r_reg.io_pol;
    assign analyzer_code_fetch_o = (r_reg.cycle_status == `STATUS_CODE);
    assign analyzer_t1_o         = (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_T1);
    assign analyzer_wait_o       = (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_WAIT);
    assign analyzer_idle_o       = (r_reg.state == cpu_bus_cycle_monitor_pkg::ST_IDLE);
    assign analyzer_ale_o        = r_reg.ale;
    assign analyzer_min_mode_o   = r_reg.pin_sync[`PIN_MIN_MODE];
    assign analyzer_hold_ack_o   = r_reg.hold_ack;
    assign analyzer_state_o      = r_reg.state;
    assign queue_level_o         = r_reg.queue_level;
    assign last_byte_was_first_o = r_reg.last_first;
    assign second_last_byte_was_first_o = r_reg.second_last_first;

endmodule : cpu_bus_cycle_monitor

// >>> verification/cpu_bus_cycle_monitor_monitor.sv
`timescale 1ns/1ps
module cpu_bus_cycle_monitor_monitor (
    // Clock, reset and bus handshake.
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // Tracker and target outputs.
    input wire logic [7:0] target_system_ctl_oe_o,
    input wire logic [2:0] analyzer_state_o,
    input wire logic       analyzer_ale_o,
    input wire logic       analyzer_t1_o,
    input wire logic       analyzer_idle_o,
    input wire logic       analyzer_wait_o,
    input wire logic       analyzer_min_mode_o,
    input wire logic       analyzer_hold_ack_o,
    input wire logic       analyzer_read_write_o,
    input wire logic       analyzer_code_fetch_o
);
    default clocking mon_clk @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    a_ale_first: assert property (analyzer_ale_o |-> analyzer_state_o == 3'h1)
        else $error("ale outside first state");
    a_ale_at_rest: assert property (analyzer_ale_o |-> $past(analyzer_state_o) inside {3'h0, 3'h5})
        else $error("ale during a cycle");
    a_cycle_order: assert property (analyzer_state_o == 3'h1 |=> analyzer_state_o == 3'h2 ##1 analyzer_state_o == 3'h3)
        else $error("states out of order");
    a_wait_place: assert property (analyzer_wait_o |-> $past(analyzer_state_o) inside {3'h3, 3'h4})
        else $error("wait state misplaced");
    a_idle_flag: assert property (analyzer_idle_o == (analyzer_state_o == 3'h0))
        else $error("idle flag wrong");
    a_t1_flag: assert property (analyzer_t1_o == (analyzer_state_o == 3'h1))
        else $error("first state flag wrong");
    a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    a_hold_float: assert property (analyzer_min_mode_o && analyzer_hold_ack_o |-> (target_system_ctl_oe_o & 8'h37) == 8'h00)
        else $error("lines driven in hold");
    a_max_drive: assert property (!analyzer_min_mode_o [*3] |-> target_system_ctl_oe_o == 8'hff)
        else $error("max mode not driven");
    a_fetch_reads: assert property (analyzer_code_fetch_o |-> analyzer_read_write_o)
        else $error("fetch not a read");

    c_wait: cover property (analyzer_wait_o);
    c_hold: cover property (analyzer_hold_ack_o);
    c_fetch: cover property (analyzer_code_fetch_o && analyzer_ale_o);
endmodule : cpu_bus_cycle_monitor_monitor

bind cpu_bus_cycle_monitor cpu_bus_cycle_monitor_monitor cpu_bus_cycle_monitor_monitor_inst (
    .clock_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .target_system_ctl_oe_o,
    .analyzer_state_o, .analyzer_ale_o, .analyzer_t1_o, .analyzer_idle_o, .analyzer_wait_o,
    .analyzer_min_mode_o,
    .analyzer_hold_ack_o, .analyzer_read_write_o, .analyzer_code_fetch_o
);

// >>> verification/proc_bus_model.sv
`timescale 1ns/1ps
module proc_bus_model (
    // Clock and target straps.
    input  wire logic        clock_i,
    input  wire logic        min_mode_i,
    input  wire logic        hold_req_i,
    // Processor pins.
    output logic      [31:0] proc_pins_o
);
    logic [2:0]  status_reg = 3'h7;
    logic [1:0]  qs_reg     = 2'h0;
    logic [19:0] addr_reg   = 20'h0;
    logic [15:0] ad_reg     = 16'h0;
    logic        bhe_n_reg  = 1'b1;
    logic        ready_reg  = 1'b1;

    // The socketed part always runs in maximum mode; only the strap and the hold request follow the target.
    assign proc_pins_o = {hold_req_i, min_mode_i, ready_reg, bhe_n_reg, addr_reg[19:16],
                          ad_reg, 3'h7, qs_reg, status_reg};

    task automatic bus_cycle(input logic [2:0] code, input logic [19:0] addr,
                             input logic bhe_n, input logic [15:0] data, input int waits);
        @(posedge clock_i);
        status_reg <= code;
        addr_reg   <= addr;
        ad_reg     <= addr[15:0];
        bhe_n_reg  <= bhe_n;
        repeat (2) @(posedge clock_i);
        status_reg <= 3'h7;
        ad_reg     <= data;
        if (waits > 0) begin
            // The tracker sees status and ready through the same two stages; ready
            // drops a cycle after status returns to passive to land in the third state.
            @(posedge clock_i);
            ready_reg <= 1'b0;
            repeat (waits) @(posedge clock_i);
            ready_reg <= 1'b1;
        end
        repeat (3) @(posedge clock_i);
        // Once hold time is over the bus floats; show a changed value, not the stale one.
        ad_reg <= ~data;
    endtask : bus_cycle

    task automatic queue_op(input logic [1:0] qs);
        @(posedge clock_i);
        qs_reg <= qs;
        @(posedge clock_i);
        qs_reg <= 2'h0;
    endtask : queue_op
endmodule : proc_bus_model

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "cpu_bus_cycle_monitor_regs.svh"
module tb;
    logic        clock_i = 1'b0, reset_n_i = 1'b0, min_mode = 1'b0, hold_req = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, proc_pins_i, rd;
    logic [19:0] analyzer_addr_o;
    logic [15:0] analyzer_data_o;
    logic [7:0]  target_system_ctl_o, target_system_ctl_oe_o, ctl_seen;
    logic [3:0]  queue_level_o;
    logic [2:0]  analyzer_state_o;
    logic        wb_ack_o, high_byte_enable_n_o, analyzer_read_write_o, analyzer_mem_io_o;
    logic        analyzer_code_fetch_o, analyzer_t1_o, analyzer_wait_o, analyzer_idle_o;
    logic        analyzer_ale_o, analyzer_min_mode_o, analyzer_hold_ack_o, rw_seen, mio_seen;
    logic        last_byte_was_first_o, second_last_byte_was_first_o;
    int          failures = 0, num_checks = 0, waits_seen = 0;

    cpu_bus_cycle_monitor cpu_bus_cycle_monitor_inst (.clock_i, .reset_n_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .proc_pins_i,
        .target_system_ctl_o, .target_system_ctl_oe_o, .analyzer_addr_o, .analyzer_data_o,
        .high_byte_enable_n_o, .analyzer_read_write_o, .analyzer_mem_io_o, .analyzer_code_fetch_o,
        .analyzer_t1_o, .analyzer_wait_o, .analyzer_idle_o, .analyzer_ale_o, .analyzer_min_mode_o,
        .analyzer_hold_ack_o, .analyzer_state_o, .queue_level_o, .last_byte_was_first_o,
        .second_last_byte_was_first_o);
    proc_bus_model proc_bus_model_inst (.clock_i(clock_i), .min_mode_i(min_mode),
        .hold_req_i(hold_req), .proc_pins_o(proc_pins_i));

    initial begin
        forever #4 clock_i = ~clock_i;
    end

    // Direction and space are sampled in the third state, where they are settled.
    always @(posedge clock_i) begin
        if (analyzer_wait_o === 1'b1) waits_seen <= waits_seen + 1;
        if (analyzer_state_o === 3'h3) begin
            rw_seen  <= analyzer_read_write_o;
            mio_seen <= analyzer_mem_io_o;
            ctl_seen <= target_system_ctl_o;
        end
    end

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            test_done();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock_i);
    endtask : wb_access

    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
        wb_access(1'b1, adr, dat);
    endtask : wb_write

    task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp, input string name);
        wb_access(1'b0, adr, 32'h0);
        chk(name, exp, rd);
    endtask : wb_read

    task automatic settle;
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (analyzer_idle_o !== 1'b1 && n < 20);
        if (analyzer_idle_o !== 1'b1) begin
            failures++;
            test_done();
        end
    endtask : settle

    task automatic cycle_test(input logic [2:0] code, input logic [19:0] addr, input logic bhe_n,
            input logic [15:0] data, input int waits, input logic [15:0] exp_data,
            input logic exp_bhe, input logic exp_mio);
        int base;
        base = waits_seen;
        proc_bus_model_inst.bus_cycle(code, addr, bhe_n, data, waits);
        settle();
        chk("wait states", waits, waits_seen - base);
        chk("read write", {31'h0, code inside {3'h1, 3'h4, 3'h5}}, {31'h0, rw_seen});
        chk("mem io", {31'h0, exp_mio}, {31'h0, mio_seen});
        chk("address", {12'h0, addr}, {12'h0, analyzer_addr_o});
        chk("data", {16'h0, exp_data}, {16'h0, analyzer_data_o});
        chk("byte enable", {31'h0, exp_bhe}, {31'h0, high_byte_enable_n_o});
    endtask : cycle_test

    initial begin
        repeat (16) @(posedge clock_i);
        chk("reset state", 32'h0, {29'h0, analyzer_state_o});
        chk("reset oe", 32'h0, {24'h0, target_system_ctl_oe_o});
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        wb_read(`REG_CTRL, 32'h1, "ctrl");
        wb_write(`REG_CYCLES, 32'h55);
        wb_read(`REG_CYCLES, 32'h0, "cycles");
        wb_read(8'h20, 32'h0, "unmapped");
        chk("pass through", 32'he7, {24'h0, target_system_ctl_o});
        $display("registers test done");
        cycle_test(3'h5, 20'h12344, 1'b0, 16'hbeef, 2, 16'hbeef, 1'b0, 1'b1);
        cycle_test(3'h2, 20'h00301, 1'b0, 16'h5a00, 0, 16'h5a00, 1'b0, 1'b0);
        wb_read(`REG_CYCLES, 32'h2, "cycles");
        wb_write(`REG_CTRL, 32'h2);
        cycle_test(3'h1, 20'hfffff, 1'b0, 16'h1234, 1, 16'h0034, 1'b1, 1'b1);
        cycle_test(3'h6, 20'h00000, 1'b0, 16'habcd, 0, 16'h00cd, 1'b1, 1'b0);
        $display("bus cycle test done");
        wb_write(`REG_CTRL, 32'h1);
        proc_bus_model_inst.queue_op(`QS_FLUSH);
        repeat (4) begin
            proc_bus_model_inst.bus_cycle(3'h4, 20'h00100, 1'b0, 16'h9090, 0);
            settle();
        end
        chk("queue full", {28'h0, `QUEUE_MAX_WIDE}, {28'h0, queue_level_o});
        proc_bus_model_inst.queue_op(`QS_FIRST);
        proc_bus_model_inst.queue_op(`QS_NEXT);
        repeat (3) @(posedge clock_i);
        chk("queue level", 32'h4, {28'h0, queue_level_o});
        chk("last first", 32'h0, {31'h0, last_byte_was_first_o});
        chk("second first", 32'h1, {31'h0, second_last_byte_was_first_o});
        proc_bus_model_inst.queue_op(`QS_FLUSH);
        repeat (3) @(posedge clock_i);
        chk("queue flushed", 32'h0, {28'h0, queue_level_o});
        $display("queue test done");
        min_mode <= 1'b1;
        hold_req <= 1'b1;
        repeat (6) @(posedge clock_i);
        chk("hold ack", 32'h1, {31'h0, analyzer_hold_ack_o});
        chk("floated", 32'h0, {24'h0, target_system_ctl_oe_o & 8'h77});
        chk("hold to target", 32'h1, {31'h0, target_system_ctl_o[7]});
        hold_req <= 1'b0;
        repeat (6) @(posedge clock_i);
        cycle_test(3'h6, 20'h00010, 1'b0, 16'h0102, 0, 16'h0102, 1'b0, 1'b1);
        chk("emulated space", 32'h1, {31'h0, ctl_seen[2]});
        $display("minimum mode test done");
        test_done();
    end
endmodule : tb
